//--- logic/rx_frame_filter.sv
`timescale 1ns/10ps
// Overview of operation
// - with sync filtering on, a valid sync frame feeds clock sync only if its id is accepted.
// - an id is accepted when ((id xor value) and mask) is zero and id differs from reject id.
// - each of the eleven sync mask bits is don't care when 0 and must match when 1.
// - sync value/mask, fifo id value/mask and fifo channel bits are writable only in config.
// - with sync filtering on, a sync frame whose id equals the reject id is not used.
// - the sync reject id register is writable in any protocol state.
// - one cycle filter register per buffer 0..58 at word 0x202 plus four times the index.
// - cycle filter holds value in bits 5..0 and mask in bits 13..8, mask 1 includes a bit.
// - a sixteen-bit fifo id value is compared against the received message id.
// - a fifo mask bit of 1 includes that message id bit, 0 excludes it.
// - channel bits select both, a only, b only, or no frames for fifo filtering.
// - fifo channel, id value and id mask reset to zero; sync and cycle filters are undefined.
module rx_frame_filter #(
  parameter int NUM_BUF = 59
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [9:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire rx_filter_pkg::rx_frame_t FRAME,
  input wire logic [5:0] CUR_CYCLE,
  output rx_filter_pkg::verdict_t VERDICT,
  output logic [NUM_BUF-1:0] CYC_MATCH
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_BUF < 1 || NUM_BUF > 59) begin : g_bad_num
    $error("NUM_BUF must be 1 to 59");
  end

  // ****************************************
  // register file
  // ****************************************
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic [15:0] fval_r, fval_nxt;
  logic [15:0] fmask_r, fmask_nxt;
  logic [10:0] smask_r, smask_nxt;
  logic [10:0] sval_r, sval_nxt;
  logic [10:0] srej_r, srej_nxt;
  logic [5:0] cval_r [NUM_BUF];
  logic [5:0] cmask_r [NUM_BUF];
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] rejcnt_r, rejcnt_nxt;
  logic config_mode;
  logic cyc_hit;
  logic [9:0] cyc_off;
  logic [9:0] cyc_idx;

  assign config_mode = ctrl_r[rx_filter_pkg::CTRL_CONFIG_BIT];
  assign cyc_off = ADDR - rx_filter_pkg::CYC_BASE_OFS;
  assign cyc_idx = {2'h0, cyc_off[9:2]};
  // cycle filter slots sit on a four-word stride above the base
  assign cyc_hit = (ADDR >= rx_filter_pkg::CYC_BASE_OFS) && (cyc_off[1:0] == 2'h0)
                   && (cyc_idx < 10'(NUM_BUF));

  // next values of the scalar registers and read mux
  always_comb begin
    ctrl_nxt = ctrl_r;
    chan_nxt = chan_r;
    fval_nxt = fval_r;
    fmask_nxt = fmask_r;
    smask_nxt = smask_r;
    sval_nxt = sval_r;
    srej_nxt = srej_r;
    rdata_nxt = 16'h0000;
    if (WR) begin
      case (ADDR)
        rx_filter_pkg::CTRL_OFS: ctrl_nxt = {14'h0000, WDATA[1:0]};
        rx_filter_pkg::SYNC_REJ_OFS: srej_nxt = WDATA[10:0];
        default: ;
      endcase
      // protected registers ignore writes outside configuration
      if (config_mode) begin
        case (ADDR)
          rx_filter_pkg::FIFO_CHAN_OFS: chan_nxt = WDATA[1:0];
          rx_filter_pkg::FIFO_VAL_OFS: fval_nxt = WDATA;
          rx_filter_pkg::FIFO_MASK_OFS: fmask_nxt = WDATA;
          rx_filter_pkg::SYNC_MASK_OFS: smask_nxt = WDATA[10:0];
          rx_filter_pkg::SYNC_VAL_OFS: sval_nxt = WDATA[10:0];
          default: ;
        endcase
      end
    end
    if (RD) begin
      case (ADDR)
        rx_filter_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
        rx_filter_pkg::STAT_OFS: rdata_nxt = rejcnt_r;
        rx_filter_pkg::FIFO_CHAN_OFS: rdata_nxt = {14'h0000, chan_r};
        rx_filter_pkg::FIFO_VAL_OFS: rdata_nxt = fval_r;
        rx_filter_pkg::FIFO_MASK_OFS: rdata_nxt = fmask_r;
        rx_filter_pkg::SYNC_MASK_OFS: rdata_nxt = {5'h00, smask_r};
        rx_filter_pkg::SYNC_VAL_OFS: rdata_nxt = {5'h00, sval_r};
        rx_filter_pkg::SYNC_REJ_OFS: rdata_nxt = {5'h00, srej_r};
        default: begin
          if (cyc_hit) begin
            rdata_nxt = {2'h0, cmask_r[cyc_idx[5:0]], 2'h0, cval_r[cyc_idx[5:0]]};
          end
        end
      endcase
    end
  end

  // scalar register storage; sync filter registers keep no reset value
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_r <= rx_filter_pkg::CTRL_RESET;
      chan_r <= rx_filter_pkg::CHAN_RESET;
      fval_r <= rx_filter_pkg::FIFO_RESET;
      fmask_r <= rx_filter_pkg::FIFO_RESET;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      chan_r <= chan_nxt;
      fval_r <= fval_nxt;
      fmask_r <= fmask_nxt;
      rdata_r <= rdata_nxt;
    end
    smask_r <= smask_nxt;
    sval_r <= sval_nxt;
    srej_r <= srej_nxt;
  end

  assign RDATA = rdata_r;

  // cycle filter array, written only in configuration, no reset
  always_ff @(posedge MCLK) begin
    if (WR && cyc_hit && config_mode) begin
      cval_r[cyc_idx[5:0]] <= WDATA[rx_filter_pkg::CYC_VAL_LSB +: 6];
      cmask_r[cyc_idx[5:0]] <= WDATA[rx_filter_pkg::CYC_MASK_LSB +: 6];
    end
  end

  // ****************************************
  // filter comparisons
  // ****************************************
  logic sync_en;
  logic sync_masked_ok;
  logic sync_not_rej;
  logic sync_accept;
  logic chan_sel;
  logic fifo_ok;
  logic [NUM_BUF-1:0] cyc_match_nxt;
  rx_filter_pkg::verdict_t verdict_r, verdict_nxt;
  logic [NUM_BUF-1:0] cyc_match_r;

  assign sync_en = ctrl_r[rx_filter_pkg::CTRL_SYNC_EN_BIT];

  // verdicts for the frame on the input, registered one cycle later
  always_comb begin
    sync_masked_ok = (((FRAME.frame_id ^ sval_r) & smask_r) == 11'h000);
    sync_not_rej = (FRAME.frame_id != srej_r);
    sync_accept = sync_masked_ok && sync_not_rej;
    // channel table: a only, b only, both, or none
    chan_sel = FRAME.chan_b ? chan_r[rx_filter_pkg::CHAN_B_BIT]
                            : chan_r[rx_filter_pkg::CHAN_A_BIT];
    fifo_ok = (((FRAME.msg_id ^ fval_r) & fmask_r) == 16'h0000);
    verdict_nxt.valid = FRAME.valid;
    verdict_nxt.sync_use = FRAME.valid && FRAME.sync && (!sync_en || sync_accept);
    verdict_nxt.fifo_accept = FRAME.valid && fifo_ok && chan_sel;
    rejcnt_nxt = rejcnt_r;
    if (FRAME.valid && FRAME.sync && sync_en && !sync_accept) begin
      rejcnt_nxt = rejcnt_r + 16'h0001; // saturation not needed, software reads a wrap count
    end
    for (int i = 0; i < NUM_BUF; i++) begin
      cyc_match_nxt[i] = (((CUR_CYCLE ^ cval_r[i]) & cmask_r[i]) == 6'h00);
    end
  end

  // verdict and match registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      verdict_r <= '0;
      cyc_match_r <= '0;
      rejcnt_r <= 16'h0000;
    end else begin
      verdict_r <= verdict_nxt;
      cyc_match_r <= cyc_match_nxt;
      rejcnt_r <= rejcnt_nxt;
    end
  end

  assign VERDICT = verdict_r;
  assign CYC_MATCH = cyc_match_r;

  // ****************************************
  // checks
  // ****************************************
  sync_rej_block_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && FRAME.frame_id == srej_r) |=> !VERDICT.sync_use)
    else $error("rejected sync id used");
  sync_accept_use_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en) |=> (VERDICT.sync_use == $past(sync_accept)))
    else $error("sync use does not follow acceptance");
  sync_mask_zero_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && smask_r == 11'h000 && FRAME.frame_id != srej_r)
    |=> VERDICT.sync_use)
    else $error("zero mask failed to accept");
  sync_id_match_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && ((FRAME.frame_id ^ sval_r) & smask_r) != 11'h000)
    |=> !VERDICT.sync_use)
    else $error("mismatched sync id accepted");
  prot_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && !config_mode && ADDR == rx_filter_pkg::FIFO_VAL_OFS) |=> $stable(fval_r))
    else $error("protected write outside configuration");
  rej_any_state_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && ADDR == rx_filter_pkg::SYNC_REJ_OFS) |=> (srej_r == $past(WDATA[10:0])))
    else $error("reject id write lost");
  chan_none_a: assert property (@(posedge MCLK) disable iff (RST)
    (chan_r == 2'h0) |=> !VERDICT.fifo_accept)
    else $error("frame accepted with no channel selected");
  fifo_mask_zero_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && fmask_r == 16'h0000 && chan_sel) |=> VERDICT.fifo_accept)
    else $error("zero fifo mask did not accept");
  fifo_id_miss_a: assert property (@(posedge MCLK) disable iff (RST)
    (((FRAME.msg_id ^ fval_r) & fmask_r) != 16'h0000) |=> !VERDICT.fifo_accept)
    else $error("mismatched message id accepted");
  reset_clear_a: assert property (@(posedge MCLK)
    RST |=> (chan_r == 2'h0 && fval_r == 16'h0000 && fmask_r == 16'h0000))
    else $error("fifo filters not cleared by reset");
  cyc_match_zero_a: assert property (@(posedge MCLK) disable iff (RST)
    (cmask_r[0] == 6'h00) |=> CYC_MATCH[0])
    else $error("cycle filter with zero mask missed");
  read_latency_a: assert property (@(posedge MCLK) disable iff (RST)
    (RD && ADDR == rx_filter_pkg::FIFO_VAL_OFS) |=> (RDATA == $past(fval_r)))
    else $error("fifo value readback wrong");

  // ****************************************
  // checks on the frame verdicts
  // ****************************************
  // only sync frames may feed clock synchronisation
  nonsync_no_use_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && !FRAME.sync) |=> !VERDICT.sync_use)
    else $error("non-sync frame used for clock sync");
  // with the filter off every valid sync frame is passed on unfiltered
  sync_off_use_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && !sync_en) |=> VERDICT.sync_use)
    else $error("sync frame dropped with filter off");
  sync_accept_full_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && FRAME.frame_id != srej_r
     && ((FRAME.frame_id ^ sval_r) & smask_r) == 11'h000) |=> VERDICT.sync_use)
    else $error("accepted sync id not used");
  // one mask bit on its own must be able to veto a frame
  sync_bit_veto_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && smask_r[8] && FRAME.frame_id[8] != sval_r[8])
    |=> !VERDICT.sync_use)
    else $error("masked id bit ignored");
  // the reject counter moves only on a filtered-out sync frame
  rej_count_step_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.sync && sync_en && !sync_accept)
    |=> (rejcnt_r == $past(rejcnt_r) + 16'h0001))
    else $error("reject counter did not step");
  rej_count_hold_a: assert property (@(posedge MCLK) disable iff (RST)
    !(FRAME.valid && FRAME.sync && sync_en && !sync_accept) |=> $stable(rejcnt_r))
    else $error("reject counter moved without a rejected frame");
  fifo_accept_full_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && chan_sel && ((FRAME.msg_id ^ fval_r) & fmask_r) == 16'h0000)
    |=> VERDICT.fifo_accept)
    else $error("matching message id not accepted");
  // a frame from a deselected channel must never reach the fifo
  chan_a_off_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && !FRAME.chan_b && !chan_r[rx_filter_pkg::CHAN_A_BIT])
    |=> !VERDICT.fifo_accept)
    else $error("channel a frame accepted while deselected");
  chan_b_off_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && FRAME.chan_b && !chan_r[rx_filter_pkg::CHAN_B_BIT])
    |=> !VERDICT.fifo_accept)
    else $error("channel b frame accepted while deselected");
  chan_both_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && chan_r == 2'h3 && fifo_ok) |=> VERDICT.fifo_accept)
    else $error("frame lost with both channels selected");
  fifo_bit_veto_a: assert property (@(posedge MCLK) disable iff (RST)
    (FRAME.valid && fmask_r[8] && FRAME.msg_id[8] != fval_r[8]) |=> !VERDICT.fifo_accept)
    else $error("masked message id bit ignored");
  verdict_valid_a: assert property (@(posedge MCLK) disable iff (RST)
    FRAME.valid |=> VERDICT.valid)
    else $error("frame left without a verdict");
  // downstream logic may sample the verdict at any time, so idle cycles show all zero
  idle_verdict_a: assert property (@(posedge MCLK) disable iff (RST)
    !FRAME.valid |=> (VERDICT == 3'h0))
    else $error("verdict raised with no frame");

  // ****************************************
  // checks on the register file
  // ****************************************
  // the remaining protected scalar registers hold their value outside configuration
  prot_chan_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && !config_mode && ADDR == rx_filter_pkg::FIFO_CHAN_OFS) |=> $stable(chan_r))
    else $error("channel bits written outside configuration");
  prot_mask_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && !config_mode && ADDR == rx_filter_pkg::FIFO_MASK_OFS) |=> $stable(fmask_r))
    else $error("fifo mask written outside configuration");
  prot_sync_val_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && !config_mode && ADDR == rx_filter_pkg::SYNC_VAL_OFS) |=> $stable(sval_r))
    else $error("sync value written outside configuration");
  prot_sync_mask_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && !config_mode && ADDR == rx_filter_pkg::SYNC_MASK_OFS) |=> $stable(smask_r))
    else $error("sync mask written outside configuration");
  // in configuration the fifo value, fifo mask and channel bits writes must land at the next edge
  cfg_val_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && config_mode && ADDR == rx_filter_pkg::FIFO_VAL_OFS) |=> (fval_r == $past(WDATA)))
    else $error("fifo value write lost");
  cfg_mask_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && config_mode && ADDR == rx_filter_pkg::FIFO_MASK_OFS) |=> (fmask_r == $past(WDATA)))
    else $error("fifo mask write lost");
  cfg_chan_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && config_mode && ADDR == rx_filter_pkg::FIFO_CHAN_OFS)
    |=> (chan_r == $past(WDATA[1:0])))
    else $error("channel bits write lost");
  rej_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (RD && ADDR == rx_filter_pkg::SYNC_REJ_OFS) |=> (RDATA == {5'h00, $past(srej_r)}))
    else $error("reject id readback wrong");
  chan_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (RD && ADDR == rx_filter_pkg::FIFO_CHAN_OFS) |=> (RDATA == {14'h0, $past(chan_r)}))
    else $error("channel bits readback wrong");
  mask_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (RD && ADDR == rx_filter_pkg::FIFO_MASK_OFS) |=> (RDATA == $past(fmask_r)))
    else $error("fifo mask readback wrong");

  // ****************************************
  // checks on the cycle filters
  // ****************************************
  cyc_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && config_mode && ADDR == rx_filter_pkg::CYC_BASE_OFS)
    |=> (cval_r[0] == $past(WDATA[5:0]) && cmask_r[0] == $past(WDATA[13:8])))
    else $error("cycle filter write lost");
  // the top slot guards against an off-by-one in the index decode
  cyc_last_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (WR && config_mode && cyc_hit && cyc_idx == 10'(NUM_BUF - 1))
    |=> (cval_r[NUM_BUF-1] == $past(WDATA[5:0])))
    else $error("last cycle filter write lost");
  cyc_last_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (RD && cyc_hit && cyc_idx == 10'(NUM_BUF - 1)) |=> (RDATA == {2'h0,
    $past(cmask_r[NUM_BUF-1]), 2'h0, $past(cval_r[NUM_BUF-1])}))
    else $error("last cycle filter readback wrong");
  cyc_hit_a: assert property (@(posedge MCLK) disable iff (RST)
    (((CUR_CYCLE ^ cval_r[0]) & cmask_r[0]) == 6'h00) |=> CYC_MATCH[0])
    else $error("cycle filter match missed");
  cyc_miss_a: assert property (@(posedge MCLK) disable iff (RST)
    (((CUR_CYCLE ^ cval_r[0]) & cmask_r[0]) != 6'h00) |=> !CYC_MATCH[0])
    else $error("cycle filter matched a wrong cycle");
  cyc_last_hit_a: assert property (@(posedge MCLK) disable iff (RST)
    (((CUR_CYCLE ^ cval_r[NUM_BUF-1]) & cmask_r[NUM_BUF-1]) == 6'h00)
    |=> CYC_MATCH[NUM_BUF-1])
    else $error("last cycle filter match missed");

endmodule : rx_frame_filter

//--- logic/rx_filter_pkg.sv
package rx_filter_pkg;

  // ****************************************
  // register offsets (word offsets as printed)
  // ****************************************
  localparam logic [9:0] FIFO_CHAN_OFS = 10'h01A;
  localparam logic [9:0] FIFO_VAL_OFS = 10'h01C;
  localparam logic [9:0] FIFO_MASK_OFS = 10'h01E;
  localparam logic [9:0] SYNC_MASK_OFS = 10'h0EE;
  localparam logic [9:0] SYNC_VAL_OFS = 10'h0F0;
  localparam logic [9:0] SYNC_REJ_OFS = 10'h0F2;
  localparam logic [9:0] CYC_BASE_OFS = 10'h202;
  localparam logic [9:0] CYC_STRIDE = 10'h004;
  localparam logic [9:0] CTRL_OFS = 10'h0F4;
  localparam logic [9:0] STAT_OFS = 10'h0F6;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ID_W = 11;
  localparam int CYC_W = 6;
  localparam int MSGID_W = 16;
  localparam int CYC_VAL_LSB = 0;
  localparam int CYC_MASK_LSB = 8;
  localparam int CHAN_A_BIT = 0;
  localparam int CHAN_B_BIT = 1;
  localparam int CTRL_CONFIG_BIT = 0;
  localparam int CTRL_SYNC_EN_BIT = 1;
  localparam logic [15:0] FIFO_RESET = 16'h0000;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [15:0] CTRL_RESET = 16'h0001;

  // received frame as presented to the filters
  typedef struct packed {
    logic valid;
    logic sync;
    logic chan_b;
    logic [ID_W-1:0] frame_id;
    logic [MSGID_W-1:0] msg_id;
    logic [CYC_W-1:0] cycle;
  } rx_frame_t;

  // filter verdicts
  typedef struct packed {
    logic valid;
    logic sync_use;
    logic fifo_accept;
  } verdict_t;

endpackage : rx_filter_pkg

//--- test/frame_src.sv
`timescale 1ns/10ps
// ****************************************
// partner: receive side frame source
// ****************************************
module frame_src (
  input wire logic clk,
  output rx_filter_pkg::rx_frame_t frame
);
  // one frame per call; between frames the fields show the inverse of the last
  // frame, so a design that samples outside valid cannot get lucky
  task automatic send(input logic s, input logic b, input logic [10:0] id,
                      input logic [15:0] m);
    @(posedge clk);
    frame <= {1'b1, s, b, id, m, 6'h00};
    @(posedge clk);
    frame <= {1'b0, ~s, ~b, ~id, ~m, 6'h3F};
  endtask : send

  initial frame = '0;
endmodule : frame_src

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [9:0] ADDR = 10'h000;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic [5:0] CUR_CYCLE = 6'h00;
  logic [58:0] CYC_MATCH;
  rx_filter_pkg::rx_frame_t FRAME;
  rx_filter_pkg::verdict_t VERDICT;
  int err_count = 0;
  int cmp_count = 0;

  rx_frame_filter #(.NUM_BUF(59)) uut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .FRAME(FRAME), .CUR_CYCLE(CUR_CYCLE),
    .VERDICT(VERDICT), .CYC_MATCH(CYC_MATCH));
  frame_src src (.clk(MCLK), .frame(FRAME));

  // 20 MHz clock
  always #25 MCLK = ~MCLK;

  // ****************************************
  // bus and frame helpers
  // ****************************************
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    `CHK("rdata", e, RDATA)
  endtask : rd_chk

  task automatic frm(input logic s, input logic b, input logic [10:0] id,
                     input logic [15:0] m, input logic es, input logic ef);
    src.send(s, b, id, m);
    #1;
    `CHK("verdict", {1'b1, es, ef}, VERDICT)
  endtask : frm

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reset_values();
    rd_chk(10'h01A, 16'h0000);
    rd_chk(10'h01C, 16'h0000);
    rd_chk(10'h01E, 16'h0000);
    rd_chk(10'h0F4, 16'h0001);
    rd_chk(10'h3FF, 16'h0000);
  endtask : reset_values

  // every channel code, both channels, a matching and a non-matching id
  task automatic fifo_filter();
    // value and mask still at reset: every selected frame passes
    wr(10'h01A, 16'h0003);
    frm(1'b0, 1'b0, 11'h001, 16'h5A5A, 1'b0, 1'b1);
    wr(10'h01C, 16'h1234);
    wr(10'h01E, 16'hFF00);
    for (int c = 0; c < 4; c++) begin
      wr(10'h01A, 16'(c));
      frm(1'b0, 1'b0, 11'h001, 16'h12AB, 1'b0, c[0]);
      frm(1'b0, 1'b1, 11'h001, 16'h12AB, 1'b0, c[1]);
      frm(1'b0, 1'b1, 11'h001, 16'h13AB, 1'b0, 1'b0);
    end
  endtask : fifo_filter

  task automatic sync_filter();
    wr(10'h0F0, 16'h0155);
    wr(10'h0EE, 16'h0000);
    // reject id changed with no frame on the way, as in the idle time
    wr(10'h0F2, 16'h0157);
    wr(10'h0F4, 16'h0003);
    frm(1'b1, 1'b0, 11'h2AA, 16'h0000, 1'b1, 1'b0);
    wr(10'h0EE, 16'h07F0);
    frm(1'b1, 1'b0, 11'h15A, 16'h0000, 1'b1, 1'b0);
    frm(1'b1, 1'b0, 11'h157, 16'h0000, 1'b0, 1'b0);
    frm(1'b1, 1'b0, 11'h255, 16'h0000, 1'b0, 1'b0);
    frm(1'b0, 1'b0, 11'h15A, 16'h0000, 1'b0, 1'b0);
    wr(10'h0F4, 16'h0001);
    frm(1'b1, 1'b0, 11'h255, 16'h0000, 1'b1, 1'b0);
    rd_chk(10'h0F6, 16'h0002);
  endtask : sync_filter

  task automatic cycle_filter();
    wr(10'h202, 16'h3F05);
    wr(10'h2EA, 16'h0101);
    rd_chk(10'h2EA, 16'h0101);
    @(posedge MCLK);
    CUR_CYCLE <= 6'h05;
    repeat (2) @(posedge MCLK);
    #1;
    `CHK("cyc5", 2'b11, {CYC_MATCH[58], CYC_MATCH[0]})
    @(posedge MCLK);
    CUR_CYCLE <= 6'h04;
    repeat (2) @(posedge MCLK);
    #1;
    `CHK("cyc4", 2'b00, {CYC_MATCH[58], CYC_MATCH[0]})
    @(posedge MCLK);
    CUR_CYCLE <= 6'h07;
    repeat (2) @(posedge MCLK);
    #1;
    `CHK("cyc7", 2'b10, {CYC_MATCH[58], CYC_MATCH[0]})
    // a cleared mask leaves every cycle bit out, whatever the value says
    wr(10'h202, 16'h0015);
    repeat (2) @(posedge MCLK);
    #1;
    `CHK("cyc_nomask", 1'b1, CYC_MATCH[0])
  endtask : cycle_filter

  // outside configuration only the reject id and the control register still take writes
  task automatic write_lock();
    wr(10'h0F4, 16'h0002);
    wr(10'h01C, 16'hBEEF);
    wr(10'h01A, 16'h0000);
    wr(10'h0F0, 16'h0000);
    wr(10'h01E, 16'h0000);
    wr(10'h0EE, 16'h0000);
    rd_chk(10'h01C, 16'h1234);
    rd_chk(10'h01E, 16'hFF00);
    rd_chk(10'h0EE, 16'h07F0);
    rd_chk(10'h01A, 16'h0003);
    rd_chk(10'h0F0, 16'h0155);
    wr(10'h0F2, 16'h015A);
    rd_chk(10'h0F2, 16'h015A);
    frm(1'b1, 1'b1, 11'h15A, 16'h12AB, 1'b0, 1'b1);
  endtask : write_lock

  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // a hang is cut short and counted
  initial begin
    repeat (20000) @(posedge MCLK);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    reset_values();
    fifo_filter();
    sync_filter();
    cycle_filter();
    write_lock();
    wrap_up();
  end
endmodule : testbench
